// ### acc_pkg.sv
/*
  Package for the analog comparator control block: control word layout, reset values,
  phase encoding and the carrier structs.
  Assumes one 100 MHz clock, an asynchronous active-high reset, and analog front ends outside.
*/
package acc_pkg;
  // Control register bit positions
  localparam int CTL_ENABLE = 7;
  localparam int CTL_RESULT = 6;
  localparam int CTL_OE = 5;
  localparam int CTL_POL = 4;
  localparam int CTL_SPEED = 3;
  localparam int CTL_REF = 2;
  localparam int CTL_CH_HI = 1;
  localparam int CTL_CH_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h08;
  // Auxiliary register of comparator 2: bit 7/6 mirrors, bit 1 timer gate sync
  localparam int AUX_MIRROR1 = 7;
  localparam int AUX_MIRROR2 = 6;
  localparam int AUX_SYNC = 1;
  localparam int AUX_GATE_SRC = 0;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] AUX_WMASK = 8'h03;
  localparam logic [7:0] CTL_WMASK = 8'hbf;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  typedef enum logic [1:0] {
    ACC_PH_ONE = 2'b00,
    ACC_PH_TWO = 2'b01,
    ACC_PH_THREE = 2'b10,
    ACC_PH_FOUR = 2'b11
  } acc_phase_e;

  // Analog outcome of one comparator, already chosen by the front end
  typedef struct packed {
    logic noninverting_above;
  } acc_analog_s;

  // Software access strobe to one control register
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } acc_access_s;
endpackage

// ### acc_comparator_ctrl.sv
/*
  Control and change-detect logic for a pair of analog comparators.
  Assumes the analog front end resolves each comparison as an asynchronous level and
  reads the enable, channel and speed settings from the exported control words.
*/
`timescale 1ns/10ps
module acc_comparator_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sleep_mode,
  input wire acc_pkg::acc_analog_s cmp1_analog,
  input wire acc_pkg::acc_analog_s cmp2_analog,
  input wire acc_pkg::acc_access_s cmp1_access,
  input wire acc_pkg::acc_access_s cmp2_access,
  input wire acc_pkg::acc_access_s cmp2_aux_access,
  input wire logic [1:0] pin_direction_bit,
  output logic [7:0] cmp1_control_reg,
  output logic [7:0] cmp2_control_reg,
  output logic [7:0] cmp2_aux_control_reg,
  output logic [1:0] cmp_pin_out,
  output logic [1:0] cmp_pin_oe,
  output logic [1:0] cmp_change_event,
  output logic phase_one_clock,
  output logic phase_three_clock
);

  ////////////////////////////////////////////////////////////////////////////////
  // Four-phase sequence

  acc_pkg::acc_phase_e phase_r;
  logic [7:0] ctl_r [2];
  logic [7:0] aux_r;
  logic [1:0] sync1_r, sync2_r, result;
  logic [1:0] acc_latch_r, smp_latch_r, mismatch_r;
  logic [1:0] pend_rd_r;
  acc_pkg::acc_access_s acc [2];
  logic [1:0] raw;

  assign acc[0] = cmp1_access;
  assign acc[1] = cmp2_access;
  assign raw = {cmp2_analog.noninverting_above, cmp1_analog.noninverting_above};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_r <= acc_pkg::ACC_PH_ONE;
    end else begin
      case (phase_r)
        acc_pkg::ACC_PH_ONE: phase_r <= acc_pkg::ACC_PH_TWO;
        acc_pkg::ACC_PH_TWO: phase_r <= acc_pkg::ACC_PH_THREE;
        acc_pkg::ACC_PH_THREE: phase_r <= acc_pkg::ACC_PH_FOUR;
        default: phase_r <= acc_pkg::ACC_PH_ONE;
      endcase
    end
  end

  // Phase strobes; phase one freezes high while asleep
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_one_clock <= 1'b0;
      phase_three_clock <= 1'b0;
    end else begin
      phase_one_clock <= sleep_mode | (phase_r == acc_pkg::ACC_PH_FOUR);
      phase_three_clock <= (phase_r == acc_pkg::ACC_PH_TWO);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_r[0] <= acc_pkg::CTL_RESET;
      ctl_r[1] <= acc_pkg::CTL_RESET;
      aux_r <= acc_pkg::AUX_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (acc[i].wr) begin
          ctl_r[i] <= acc[i].wdata & acc_pkg::CTL_WMASK;
        end
      end
      if (cmp2_aux_access.wr) begin
        aux_r <= cmp2_aux_access.wdata & acc_pkg::AUX_WMASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronizer, polarity and change detect

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  // Off comparator gives zero into polarity; the polarity bit then presets the level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      result[i] = (sync2_r[i] & ctl_r[i][acc_pkg::CTL_ENABLE]) ^ ctl_r[i][acc_pkg::CTL_POL];
    end
  end

  // An access marks the access latch; it loads at the next phase three
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_rd_r <= 2'h0;
      acc_latch_r <= 2'h0;
      smp_latch_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (phase_three_clock) begin
          // An access on this very edge is served now; keeping it pending would reload later
          pend_rd_r[i] <= 1'b0;
          if (pend_rd_r[i] | acc[i].rd | acc[i].wr) begin
            acc_latch_r[i] <= result[i];
          end
        end else if (acc[i].rd | acc[i].wr) begin
          pend_rd_r[i] <= 1'b1;
        end
        if (phase_one_clock && !sleep_mode) begin
          smp_latch_r[i] <= result[i];
        end
      end
    end
  end

  // Event on rising edge of the mismatch only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mismatch_r <= 2'h0;
      cmp_change_event <= 2'h0;
    end else begin
      mismatch_r <= acc_latch_r ^ smp_latch_r;
      cmp_change_event <= (acc_latch_r ^ smp_latch_r) & ~mismatch_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp1_control_reg <= acc_pkg::CTL_RESET;
      cmp2_control_reg <= acc_pkg::CTL_RESET;
      cmp2_aux_control_reg <= acc_pkg::AUX_RESET;
      cmp_pin_out <= 2'h0;
      cmp_pin_oe <= 2'h0;
    end else begin
      cmp1_control_reg <= {ctl_r[0][7], result[0], ctl_r[0][5:0]};
      cmp2_control_reg <= {ctl_r[1][7], result[1], ctl_r[1][5:0]};
      cmp2_aux_control_reg <= {result[0], result[1], aux_r[5:0]};
      cmp_pin_out <= result;
      for (int i = 0; i < 2; i++) begin
        cmp_pin_oe[i] <= ctl_r[i][acc_pkg::CTL_OE] & ~pin_direction_bit[i]
                         & ctl_r[i][acc_pkg::CTL_ENABLE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_sleep_phase;
    @(posedge clk) disable iff (sys_rst) sleep_mode |=> phase_one_clock;
  endproperty
  a_sleep_phase: assert property (p_sleep_phase) else $error("phase one low in sleep");

  property p_phase_spacing;
    @(posedge clk) disable iff (sys_rst)
      (phase_three_clock && !sleep_mode) |-> ##2 phase_one_clock;
  endproperty
  a_phase_spacing: assert property (p_phase_spacing) else $error("phase order wrong");

  property p_off_zero;
    @(posedge clk) disable iff (sys_rst)
      (!ctl_r[0][acc_pkg::CTL_ENABLE] && !ctl_r[0][acc_pkg::CTL_POL]) |-> !result[0];
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("off comparator not zero");

  sequence s_sync_in;
    ctl_r[0][acc_pkg::CTL_ENABLE] && !ctl_r[0][acc_pkg::CTL_POL] ##0 raw[0];
  endsequence
  // A write in the middle cycle may change the setting the result is read under
  property p_sync_delay;
    @(posedge clk) disable iff (sys_rst)
      (s_sync_in ##1 (raw[0] && ctl_r[0][acc_pkg::CTL_ENABLE] && !ctl_r[0][acc_pkg::CTL_POL]
        && !cmp1_access.wr)) |=> (sync2_r[0] && result[0]);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync path wrong");

  property p_pol;
    @(posedge clk) disable iff (sys_rst)
      ##1 cmp2_control_reg[acc_pkg::CTL_RESULT] == $past(result[1]);
  endproperty
  a_pol: assert property (p_pol) else $error("reported result wrong");

  property p_pin;
    @(posedge clk) disable iff (sys_rst)
      (ctl_r[1][acc_pkg::CTL_OE] && !pin_direction_bit[1] && ctl_r[1][7]) |=> cmp_pin_oe[1];
  endproperty
  a_pin: assert property (p_pin) else $error("pin not driven");

  property p_pin_off;
    @(posedge clk) disable iff (sys_rst) !ctl_r[0][acc_pkg::CTL_ENABLE] |=> !cmp_pin_oe[0];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while off");

  property p_wr;
    @(posedge clk) disable iff (sys_rst)
      cmp1_access.wr |=> ctl_r[0] == ($past(cmp1_access.wdata) & acc_pkg::CTL_WMASK);
  endproperty
  a_wr: assert property (p_wr) else $error("control write lost");

  property p_mirror;
    @(posedge clk) disable iff (sys_rst)
      ##1 cmp2_aux_control_reg[acc_pkg::AUX_MIRROR1] == cmp1_control_reg[acc_pkg::CTL_RESULT];
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror mismatch");

  property p_event;
    @(posedge clk) disable iff (sys_rst)
      cmp_change_event[0] |-> (acc_latch_r[0] != smp_latch_r[0]) ##1 !cmp_change_event[0];
  endproperty
  a_event: assert property (p_event) else $error("event without mismatch");

endmodule // acc_comparator_ctrl

// ### acc_analog_model.sv
/*
  Far-side model of one comparator's analog front end: four pin levels and a
  noninverting level, resolved to the raw outcome the control block samples.
  Assumes the bench sets levels as plain codes and the control word picks the pin.
*/
`timescale 1ns/10ps
module acc_analog_model (
  input wire logic [7:0] pos_level,
  input wire logic [31:0] pin_levels,
  input wire logic [1:0] ch_sel,
  output acc_pkg::acc_analog_s analog
);
  logic [7:0] neg_level;
  // Select field routes one of four pins to the inverting side
  assign neg_level = pin_levels[{ch_sel, 3'h0} +: 8];
  // Ties give low, as the output is only high when strictly above
  assign analog.noninverting_above = pos_level > neg_level;
endmodule // acc_analog_model

// ### testbench.sv
/*
  Self-checking bench for the comparator control block.
  Assumes the analog model above and the package's control word layout.
*/
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sleep_mode = 1'b0;
  logic [1:0] pin_direction_bit = 2'h3; // pins stay inputs until the pin test
  logic [7:0] pos1 = 8'h80;
  logic [7:0] pos2 = 8'h00;
  logic [31:0] pins = 32'hffffffff;
  acc_pkg::acc_analog_s an1, an2;
  acc_pkg::acc_access_s a1 = '0, a2 = '0, a3 = '0;
  logic [7:0] c1, c2, aux;
  logic [1:0] pout, poe, ev;
  logic ph1, ph3;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  always #5 clk = ~clk;
  acc_analog_model m1 (.pos_level(pos1), .pin_levels(pins), .ch_sel(c1[1:0]), .analog(an1));
  acc_analog_model m2 (.pos_level(pos2), .pin_levels(pins), .ch_sel(c2[1:0]), .analog(an2));
  acc_comparator_ctrl uut (.clk(clk), .sys_rst(sys_rst), .sleep_mode(sleep_mode),
    .cmp1_analog(an1), .cmp2_analog(an2), .cmp1_access(a1), .cmp2_access(a2),
    .cmp2_aux_access(a3), .pin_direction_bit(pin_direction_bit), .cmp1_control_reg(c1),
    .cmp2_control_reg(c2), .cmp2_aux_control_reg(aux), .cmp_pin_out(pout), .cmp_pin_oe(poe),
    .cmp_change_event(ev), .phase_one_clock(ph1), .phase_three_clock(ph3));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Strobe lasts one cycle; the wait covers store, copy and the result path
  task automatic acc(input int w, input logic r, input logic [7:0] d);
    acc_pkg::acc_access_s a;
    a = '{rd: r, wr: !r, wdata: d};
    if (w == 0) a1 = a; else if (w == 1) a2 = a; else a3 = a;
    cyc(1);
    a1 = '0;
    a2 = '0;
    a3 = '0;
    cyc(6);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic count_ev(input int idx, output int k);
    k = 0;
    repeat (16) begin
      cyc(1);
      if (ev[idx] === 1'b1) k++;
    end
  endtask
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    sys_rst = 1'b0;
    cyc(1);
    chk("cmp1 ctl", 8'h08, c1);
    chk("cmp2 ctl", 8'h08, c2);
    chk("aux", 8'h00, aux);
    chk("oe", 8'h00, {6'h0, poe});
    n = 0;
    repeat (8) begin
      cyc(1);
      n += ph3;
    end
    chk("phase three count", 8'h02, n[7:0]);
    // Only the selected pin sits below the noninverting level
    for (int ch = 0; ch < 4; ch++) begin
      pins = 32'hffffffff;
      pins[ch*8 +: 8] = 8'h10;
      acc(0, 1'b0, 8'h80 | 8'(ch));
      chk("channel result", 8'hc0 | 8'(ch), c1);
    end
    acc(0, 1'b0, 8'h93);
    chk("inverted", 8'h93, c1);
    pin_direction_bit = 2'h0;
    acc(0, 1'b0, 8'ha3);
    chk("pin oe on", 8'h01, {6'h0, poe});
    chk("pin out", 8'h01, {6'h0, pout});
    pin_direction_bit = 2'h1;
    cyc(3);
    chk("pin oe off", 8'h00, {7'h0, poe[0]});
    acc(0, 1'b1, 8'h00);
    pins[31:24] = 8'hff;
    count_ev(0, n);
    chk("change event", 8'h01, n[7:0]);
    chk("result fell", 8'ha3, c1);
    // Disabled comparator must stay silent whatever the inputs do
    acc(0, 1'b0, 8'h03);
    acc(0, 1'b1, 8'h00);
    pins[31:24] = 8'h10;
    count_ev(0, n);
    chk("off event", 8'h00, n[7:0]);
    chk("off ctl", 8'h03, c1);
    acc(1, 1'b0, 8'hb0);
    chk("cmp2 ctl", 8'hf0, c2);
    chk("cmp2 pin oe", 8'h02, {6'h0, poe});
    acc(2, 1'b0, 8'hff); // no timer clock here, so the sync bit is harmless
    chk("aux mirror", 8'h43, aux);
    // Read first so the access latch holds the settled result before the input moves
    acc(1, 1'b1, 8'h00);
    pins[7:0] = 8'h10;
    pos2 = 8'h80;
    count_ev(1, n);
    chk("cmp2 event", 8'h01, n[7:0]);
    chk("aux mirror fell", 8'h03, aux);
    // Mid-run reset must undo every setting
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    cyc(1);
    chk("cmp1 ctl rst", 8'h08, c1);
    chk("cmp2 ctl rst", 8'h08, c2);
    chk("aux rst", 8'h00, aux);
    chk("oe rst", 8'h00, {6'h0, poe});
    sleep_mode = 1'b1;
    n = 0;
    repeat (8) begin
      cyc(1);
      n += ph1;
    end
    chk("sleep phase one", 8'h08, n[7:0]);
    conclude();
  end
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
endmodule // testbench
